// [hdl/relay_scan_sequencer.sv]
// relay scan sequencer with ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none
module relay_scan_sequencer (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // trigger inputs
   input wire logic ext_trig,
   // relay and display
   output logic [15:0] relay_close,
   output logic [6:0] relay_card,
   output logic [15:0] monitor_chan,
   output logic monitor_valid,
   // trigger out and interrupt
   output logic trig_out_n,
   output logic irq
);
   import scan_pkg::*;

   // bus address phase capture
   logic wr_pend_r;
   logic [7:0] addr_r;
   logic [17:0] rd_sel_r;
   logic [31:0] hrdata_r;

   // settings
   logic continuous_scan_enable_r;
   logic tout_en_r;
   logic mon_en_r;
   trig_src_e src_r;
   logic [14:0] count_r;
   logic [1:0] qsel_r;
   logic [6:0] mon_card_r;
   logic [6:0] last_card_r;
   logic [11:0] list_r [LIST_DEPTH];
   logic [4:0] list_len_r;
   logic list_valid_r;

   // scan engine
   scan_state_e state_r;
   logic [3:0] pos_r;
   logic [14:0] done_cnt_r;
   logic from_panel_r;
   logic [15:0] close_r;
   logic [6:0] card_r;
   logic [15:0] card_state_r [4];
   logic [2:0] irq_st_r;
   logic [2:0] irq_en_r;
   logic close_ev;

   wire logic addr_ok = hsel && hready && htrans[1];
   wire logic wr = wr_pend_r;
   wire logic [31:0] wd = hwdata;
   wire logic cmd_wr = wr && (addr_r == A_CMD);
   wire logic start_cmd = cmd_wr && wd[CMD_START];
   wire logic abort_cmd = cmd_wr && wd[CMD_ABORT];
   wire logic rst_cmd = cmd_wr && wd[CMD_RESET];
   wire logic ifc_cmd = cmd_wr && wd[CMD_IFC];
   // bit 5 together with start only marks a panel start, it must not stop that start
   wire logic local_cmd = cmd_wr && wd[CMD_LOCAL] && !wd[CMD_START];
   wire logic bus_trig = cmd_wr && wd[CMD_TRIG];

   function automatic logic [15:0] onehot(input logic [3:0] ch);
      onehot = 16'h0001 << ch;
   endfunction

   function automatic logic card_ok(input logic [6:0] c);
      card_ok = (c >= 7'd1) && (c <= CARD_MAX);
   endfunction

   // bus slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok && hwrite;
         addr_r <= haddr[7:0];
      end
   end

   // trigger from selected source
   logic trig;
   always_comb begin
      unique case (src_r)
         SRC_IMM: trig = 1'b1;
         SRC_BUS: trig = bus_trig;
         SRC_EXT: trig = ext_trig;
         SRC_HOLD: trig = 1'b0;
      endcase
   end

   // stop conditions; abort only bites on bus/hold sources
   wire logic abort_stop = abort_cmd && !from_panel_r && ((src_r == SRC_BUS) || (src_r == SRC_HOLD));
   wire logic ifc_stop = ifc_cmd && !from_panel_r;
   wire logic panel_stop = from_panel_r && (rst_cmd || local_cmd);
   wire logic stop = abort_stop || ifc_stop || panel_stop || rst_cmd || local_cmd;
   wire logic start_ok = start_cmd && list_valid_r && (list_len_r != 5'h00);
   wire logic start_bad = start_cmd && !start_ok;
   wire logic last_pos = ({1'b0, pos_r} == list_len_r - 5'h01);
   wire logic adv = (state_r == ST_SCAN) && trig && !stop && !start_cmd;

   // settings registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         continuous_scan_enable_r <= 1'b0;
         tout_en_r <= 1'b0;
         mon_en_r <= 1'b0;
         src_r <= SRC_IMM;
         count_r <= COUNT_RST;
         qsel_r <= Q_VALUE;
         mon_card_r <= CARD_AUTO;
      end else if (rst_cmd) begin
         continuous_scan_enable_r <= 1'b0;
         tout_en_r <= 1'b0;
         mon_en_r <= 1'b0;
         src_r <= SRC_IMM;
         count_r <= COUNT_RST;
         mon_card_r <= CARD_AUTO;
      end else if (abort_cmd) begin
         continuous_scan_enable_r <= 1'b0;
         count_r <= COUNT_RST;
         src_r <= SRC_IMM;
      end else if (wr) begin
         if (addr_r == A_CTRL) begin
            continuous_scan_enable_r <= wd[CTRL_CONT];
            tout_en_r <= wd[CTRL_TOUT];
            mon_en_r <= wd[CTRL_MONEN];
            src_r <= trig_src_e'(wd[CTRL_SRC_LO +: 2]);
         end
         if (addr_r == A_COUNT) begin
            qsel_r <= wd[17:16];
            if (wd[14:0] != 15'h0000) begin
               count_r <= wd[14:0];
            end
         end
         if ((addr_r == A_MON) && (card_ok(wd[6:0]) || (wd[6:0] == CARD_AUTO))) begin
            mon_card_r <= wd[6:0];
         end
      end
   end

   // channel list: each write with bit 31 clear appends card(10:4) and channel(3:0), up to 16 entries
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         list_len_r <= 5'h00;
         list_valid_r <= 1'b0;
         for (int i = 0; i < LIST_DEPTH; i++) begin
            list_r[i] <= 12'h000;
         end
      end else if (abort_cmd || rst_cmd) begin
         list_len_r <= 5'h00;
         list_valid_r <= 1'b0;
      end else if (wr && (addr_r == A_LIST)) begin
         if (wd[31]) begin
            list_len_r <= 5'h00;
            list_valid_r <= 1'b1;
         end else if (list_len_r != 5'(LIST_DEPTH)) begin
            list_r[list_len_r[3:0]] <= wd[11:0];
            list_len_r <= list_len_r + 5'h01;
            if (!card_ok(wd[10:4]) || wd[11]) begin
               list_valid_r <= 1'b0;
            end
         end
      end
   end

   // scan engine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         pos_r <= 4'h0;
         done_cnt_r <= 15'h0000;
         from_panel_r <= 1'b0;
      end else if (stop) begin
         state_r <= ST_IDLE;
      end else if (start_ok) begin
         state_r <= ST_SCAN;
         pos_r <= 4'h0;
         done_cnt_r <= 15'h0000;
         from_panel_r <= wd[CMD_LOCAL];
      end else if (adv) begin
         if (!last_pos) begin
            pos_r <= pos_r + 4'h1;
         end else if (continuous_scan_enable_r) begin
            pos_r <= 4'h0;
         end else if (done_cnt_r + 15'h0001 < count_r) begin
            pos_r <= 4'h0;
            done_cnt_r <= done_cnt_r + 15'h0001;
         end else begin
            state_r <= ST_IDLE;
            done_cnt_r <= done_cnt_r + 15'h0001;
         end
      end
   end

   assign close_ev = start_ok || (adv && (!last_pos || continuous_scan_enable_r ||
                     (done_cnt_r + 15'h0001 < count_r)));

   // relay drive and per-card state for monitor
   logic [3:0] nxt_idx;
   assign nxt_idx = start_ok ? 4'h0 : (last_pos ? 4'h0 : pos_r + 4'h1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         close_r <= 16'h0000;
         card_r <= 7'h00;
         last_card_r <= 7'h01;
         for (int i = 0; i < 4; i++) begin
            card_state_r[i] <= 16'h0000;
         end
      end else if (stop || (adv && !close_ev)) begin
         close_r <= 16'h0000;
         for (int i = 0; i < 4; i++) begin
            card_state_r[i] <= 16'h0000;
         end
      end else if (close_ev) begin
         close_r <= onehot(list_r[nxt_idx][3:0]);
         card_r <= list_r[nxt_idx][10:4];
         last_card_r <= list_r[nxt_idx][10:4];
         for (int i = 0; i < 4; i++) begin
            card_state_r[i] <= (list_r[nxt_idx][5:4] == 2'(i)) ? onehot(list_r[nxt_idx][3:0]) : 16'h0000;
         end
      end
   end

   assign relay_close = close_r;
   assign relay_card = card_r;

   // monitor view; only low card bits kept, a limit of this shadow
   wire logic [6:0] mon_sel = (mon_card_r == CARD_AUTO) ? last_card_r : mon_card_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         monitor_chan <= 16'h0000;
         monitor_valid <= 1'b0;
      end else begin
         monitor_valid <= mon_en_r;
         monitor_chan <= mon_en_r ? card_state_r[mon_sel[1:0]] : 16'h0000;
      end
   end

   trig_pulse u_pulse (
      .hclk(hclk),
      .hresetn(hresetn),
      .fire(close_ev && tout_en_r),
      .trig_out_n(trig_out_n)
   );

   // interrupts: set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_r <= 3'h0;
         irq_en_r <= 3'h0;
      end else begin
         if (wr && (addr_r == A_IRQ_EN)) begin
            irq_en_r <= wd[2:0];
         end
         irq_st_r <= (irq_st_r & ~((wr && (addr_r == A_IRQ_CLR)) ? wd[2:0] : 3'h0)) |
                     {close_ev, start_bad, adv && (state_r == ST_SCAN) && !close_ev};
      end
   end
   assign irq = |(irq_st_r & irq_en_r);

   // read mux, registered on address phase
   logic [31:0] rd_nxt;
   always_comb begin
      rd_nxt = 32'h0000_0000;
      unique case (haddr[7:0])
         A_CTRL: rd_nxt = {26'h0, src_r, 1'b0, mon_en_r, tout_en_r, continuous_scan_enable_r};
         A_COUNT: begin
            unique case (qsel_r)
               Q_MIN: rd_nxt = {17'h0, COUNT_MIN};
               Q_MAX: rd_nxt = {17'h0, COUNT_MAX};
               default: rd_nxt = {17'h0, count_r};
            endcase
         end
         A_MON: rd_nxt = {25'h0, mon_card_r};
         A_STATUS: rd_nxt = {10'h0, done_cnt_r, list_valid_r, list_len_r, state_r == ST_SCAN};
         A_IRQ_ST: rd_nxt = {29'h0, irq_st_r};
         A_IRQ_EN: rd_nxt = {29'h0, irq_en_r};
         A_CHAN: rd_nxt = {12'h0, pos_r, close_r};
         A_SWITCH: rd_nxt = {25'h0, last_card_r};
         A_MONVIEW: rd_nxt = {16'h0, monitor_chan};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         hrdata_r <= rd_nxt;
      end
   end
endmodule
`default_nettype wire

// [include/scan_pkg.sv]
// constants and types for the relay scan sequencer
// Operation
// - abort drops list, cycle count to one, continuous off, trigger source immediate
// - abort halts host-started scan only with bus or hold trigger source
// - non-continuous start runs 1 to 32767 cycles per cycle count, default 1
// - cycle count query returns stored value, 1 for min, 32767 for max
// - monitor card 1 to 99, or auto follows last switched card
// - monitor enable presents selected card channel states, cleared stops it; code keys on low two card bits only, cards four apart alias
// - start closes first list channel, each trigger advances to next
// - continuous mode wraps from last channel to first forever
// - non-continuous trigger on last channel opens it and ends cycle
// - start with invalid list flags error and does not scan
// - continuous query reports on when enabled, off when disabled
// - trigger output enable set by on/1, cleared by off/0; gates pulse
// - interface clear stops host-started scan under any trigger source
// - panel-started scan stopped by host reset or local reset/clear
// - enabled trigger output pulses low once per channel close; reset clears enable
// - reset command leaves every channel open
package scan_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned PULSE_NS = 1000;
   localparam int unsigned PULSE_CYC = ((PULSE_NS * (CLK_HZ / 1000000)) + 999) / 1000;

   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CMD = 8'h04;
   localparam logic [7:0] A_COUNT = 8'h08;
   localparam logic [7:0] A_MON = 8'h0c;
   localparam logic [7:0] A_LIST = 8'h10;
   localparam logic [7:0] A_STATUS = 8'h14;
   localparam logic [7:0] A_IRQ_ST = 8'h18;
   localparam logic [7:0] A_IRQ_EN = 8'h1c;
   localparam logic [7:0] A_IRQ_CLR = 8'h20;
   localparam logic [7:0] A_CHAN = 8'h24;
   localparam logic [7:0] A_SWITCH = 8'h28;
   localparam logic [7:0] A_MONVIEW = 8'h2c;

   // ctrl bits
   localparam int CTRL_CONT = 0;
   localparam int CTRL_TOUT = 1;
   localparam int CTRL_MONEN = 2;
   localparam int CTRL_SRC_LO = 4;
   // command bits (write one to act)
   localparam int CMD_START = 0;
   localparam int CMD_ABORT = 1;
   localparam int CMD_RESET = 2;
   localparam int CMD_IFC = 3;
   localparam int CMD_TRIG = 4;
   localparam int CMD_LOCAL = 5;
   // count register query selector, bits 17:16
   localparam logic [1:0] Q_VALUE = 2'h0;
   localparam logic [1:0] Q_MIN = 2'h1;
   localparam logic [1:0] Q_MAX = 2'h2;

   localparam logic [14:0] COUNT_MIN = 15'h0001;
   localparam logic [14:0] COUNT_MAX = 15'h7fff;
   localparam logic [14:0] COUNT_RST = 15'h0001;
   localparam int LIST_DEPTH = 16;
   localparam logic [6:0] CARD_MAX = 7'd99;
   localparam logic [6:0] CARD_AUTO = 7'h00;

   // irq status bits
   localparam int EV_DONE = 0;
   localparam int EV_ERR = 1;
   localparam int EV_CLOSE = 2;

   typedef enum logic [1:0] {
      SRC_IMM = 2'b00,
      SRC_BUS = 2'b01,
      SRC_EXT = 2'b10,
      SRC_HOLD = 2'b11
   } trig_src_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SCAN = 2'b01
   } scan_state_e;
endpackage

// [hdl/trig_pulse.sv]
// negative-going trigger output pulse stretcher
`timescale 1ns/10ps
`default_nettype none
module trig_pulse (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire logic fire,
   // pin
   output logic trig_out_n
);
   import scan_pkg::*;

   logic [7:0] cnt_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 8'h00;
      end else if (fire) begin
         cnt_r <= 8'(PULSE_CYC);
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end
   end

   assign trig_out_n = (cnt_r == 8'h00);
endmodule
`default_nettype wire

// [tb/relay_scan_sequencer_properties.sv]
// port assertions for the scan sequencer
`timescale 1ns/10ps
`default_nettype none
module scan_checker (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // relays, display, trigger
   input wire logic [15:0] relay_close,
   input wire logic [6:0] relay_card,
   input wire logic [15:0] monitor_chan,
   input wire logic monitor_valid,
   input wire logic trig_out_n
);
   import scan_pkg::*;
   logic [7:0] low_r;
   // width of a pulse is only known when it ends, so count while low
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         low_r <= 8'h00;
      else
         low_r <= trig_out_n ? 8'h00 : low_r + 8'h01;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout) else $error("wait state inserted");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_pulse_len: assert property ($rose(trig_out_n) |-> low_r == 8'(PULSE_CYC))
      else $error("trigger pulse width wrong");
   a_pulse_hold: assert property ($fell(trig_out_n) |=> !trig_out_n [*8])
      else $error("trigger pulse too short");
   a_pulse_close: assert property ($fell(trig_out_n) |-> relay_close != 16'h0000)
      else $error("pulse without closed channel");
   a_one_closed: assert property ($onehot0(relay_close))
      else $error("more than one channel closed");
   a_card_range: assert property (relay_close != 16'h0000 |-> relay_card <= CARD_MAX)
      else $error("card out of range");
   a_mon_quiet: assert property (!monitor_valid && !$past(monitor_valid) |-> monitor_chan == 16'h0000)
      else $error("monitor shown while disabled");
   c_pulse: cover property ($fell(trig_out_n));
   c_open: cover property ($fell(|relay_close));
   c_mon: cover property (monitor_valid && monitor_chan != 16'h0000);
endmodule
bind relay_scan_sequencer scan_checker scan_checker_i (.hclk, .hresetn, .hreadyout, .hresp, .relay_close,
   .relay_card, .monitor_chan, .monitor_valid, .trig_out_n);
`default_nettype wire

// [tb/ahb_host.sv]
// bus master standing in for the host computer
`timescale 1ns/10ps
`default_nettype none
module ahb_host (
   // clock
   input wire logic hclk,
   // bus
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // entered just after an edge; idle data lines toggle so stale data never looks valid
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
endmodule
`default_nettype wire

// [tb/test_relay_scan_sequencer.sv]
// self-checking bench for the scan sequencer
`timescale 1ns/10ps
`default_nettype none
module test_relay_scan_sequencer;
   import scan_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ext_trig = 1'b0;
   logic hsel, hwrite, hready, hreadyout, hresp, monitor_valid, trig_out_n, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] relay_close, monitor_chan;
   logic [6:0] relay_card;
   logic [3:0] ch [3];
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   assign hready = hreadyout;
   always #20 hclk = ~hclk;
   relay_scan_sequencer relay_scan_sequencer_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .ext_trig, .relay_close, .relay_card, .monitor_chan,
      .monitor_valid, .trig_out_n, .irq);
   ahb_host ahb_host_i (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata);
   task automatic end_of_test;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_host_i.xfer(1'b1, a, d, q);
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      ahb_host_i.xfer(1'b0, a, 32'h0, q);
      check(what, q & m, e);
   endtask
   // outputs are read one step after the edge so register updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   function automatic logic [31:0] oh(input logic [3:0] c);
      return 32'h1 << c;
   endfunction
   task automatic load(input logic [6:0] card);
      wr(A_LIST, 32'h8000_0000);
      for (int k = 0; k < 3; k++) begin
         ch[k] = 4'(k * 5 + $urandom_range(4, 0));
         wr(A_LIST, {21'h0, card, ch[k]});
      end
   endtask
   task automatic adv(input int from, input int upto);
      for (int k = from; k < upto; k++) begin
         wr(A_CMD, 32'h10);
         tick(2);
         check("position", 32'(relay_close), oh(ch[k % 3]));
      end
   endtask
   initial begin
      logic [14:0] cnt;
      logic [1:0] src;
      logic lo;
      void'($urandom(91444));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      tick(1);
      rdchk("ctrl", A_CTRL, 32'h37, 32'h0);
      rdchk("count", A_COUNT, 32'h7fff, 32'h1);
      rdchk("mon", A_MON, 32'h7f, 32'h0);
      rdchk("unmapped", 8'h30, 32'hffff_ffff, 32'h0);
      check("trig out", 32'(trig_out_n), 32'h1);
      check("relays", 32'(relay_close), 32'h0);
      cnt = 15'($urandom_range(32767, 1));
      wr(A_COUNT, {17'h0, cnt});
      rdchk("count", A_COUNT, 32'h7fff, {17'h0, cnt});
      wr(A_COUNT, 32'h1_0000);
      rdchk("count min", A_COUNT, 32'h7fff, 32'h1);
      wr(A_COUNT, 32'h2_0000);
      rdchk("count max", A_COUNT, 32'h7fff, 32'h7fff);
      wr(A_COUNT, 32'h2);
      $display("test reset and count done");
      load(7'd1);
      wr(A_CTRL, 32'(SRC_BUS) << 4);
      wr(A_CMD, 32'h1);
      tick(2);
      check("first", 32'(relay_close), oh(ch[0]));
      adv(1, 6);
      wr(A_CMD, 32'h10);
      tick(2);
      check("end open", 32'(relay_close), 32'h0);
      rdchk("cycles", A_STATUS, 32'h3f_ff81, 32'h100);
      rdchk("done irq", A_IRQ_ST, 32'h1, 32'h1);
      wr(A_CTRL, 32'h1 | (32'(SRC_BUS) << 4));
      rdchk("cont", A_CTRL, 32'h1, 32'h1);
      wr(A_CMD, 32'h1);
      tick(2);
      adv(1, 8);
      $display("test scan done");
      for (int s = 0; s < 4; s++) begin
         src = 2'(s);
         load(7'($urandom_range(99, 1)));
         wr(A_CTRL, 32'h1 | (32'(src) << 4));
         wr(A_CMD, 32'h1);
         tick(2);
         rdchk("running", A_STATUS, 32'h1, 32'h1);
         if (src == SRC_EXT) begin
            ext_trig <= 1'b1;
            @(posedge hclk);
            ext_trig <= 1'b0;
            tick(2);
            check("ext step", 32'(relay_close), oh(ch[1]));
            wr(A_CMD, 32'h2);
            rdchk("abort ignored", A_STATUS, 32'h1, 32'h1);
         end
         wr(A_CMD, (src == SRC_BUS || src == SRC_HOLD) ? 32'h2 : 32'h8);
         tick(1);
         rdchk("stopped", A_STATUS, 32'h1, 32'h0);
      end
      rdchk("abort ctrl", A_CTRL, 32'h31, 32'h0);
      rdchk("abort count", A_COUNT, 32'h7fff, 32'h1);
      $display("test stop done");
      wr(A_LIST, 32'h8000_0000);
      wr(A_LIST, 32'h800);
      wr(A_IRQ_EN, 32'h2);
      wr(A_CMD, 32'h1);
      tick(2);
      check("err irq", 32'(irq), 32'h1);
      rdchk("no scan", A_STATUS, 32'h1, 32'h0);
      wr(A_IRQ_EN, 32'h0);
      tick(1);
      check("masked", 32'(irq), 32'h0);
      wr(A_IRQ_EN, 32'h2);
      wr(A_IRQ_CLR, 32'h2);
      tick(1);
      check("cleared", 32'(irq), 32'h0);
      $display("test error done");
      load(7'd1);
      wr(A_CTRL, 32'h2 | (32'(SRC_BUS) << 4));
      wr(A_CMD, 32'h1);
      tick(1);
      check("pulse", 32'(trig_out_n), 32'h0);
      tick(PULSE_CYC + 2);
      check("pulse end", 32'(trig_out_n), 32'h1);
      wr(A_CTRL, 32'(SRC_BUS) << 4);
      wr(A_CMD, 32'h10);
      lo = 1'b0;
      repeat (30) begin
         @(posedge hclk);
         lo = lo | !trig_out_n;
      end
      check("no pulse", 32'(lo), 32'h0);
      wr(A_MON, 32'h2);
      wr(A_MON, 32'd100);
      rdchk("mon card", A_MON, 32'h7f, 32'h2);
      wr(A_CTRL, 32'h4 | (32'(SRC_BUS) << 4));
      tick(2);
      check("monitor", 32'(monitor_chan), 32'h0);
      check("mon on", 32'(monitor_valid), 32'h1);
      wr(A_MON, 32'h0);
      tick(2);
      check("auto", 32'(monitor_chan), oh(ch[1]));
      wr(A_CTRL, 32'(SRC_BUS) << 4);
      tick(2);
      check("mon off", 32'(monitor_valid), 32'h0);
      wr(A_CMD, 32'h8);
      $display("test output and monitor done");
      for (int s = 0; s < 2; s++) begin
         load(7'd2);
         wr(A_CTRL, 32'(SRC_BUS) << 4);
         wr(A_CMD, 32'h21);
         tick(2);
         check("panel run", 32'(relay_close), oh(ch[0]));
         check("panel card", 32'(relay_card), 32'h2);
         wr(A_CMD, s == 0 ? 32'h4 : 32'h20);
         tick(2);
         check("panel stop", 32'(relay_close), 32'h0);
         rdchk("panel idle", A_STATUS, 32'h1, 32'h0);
      end
      $display("test panel done");
      end_of_test();
   end
endmodule
`default_nettype wire
